// File: hw/efab_top.sv
/*
 * Alarm, AIS insertion, line coding, loopback and 511-bit tester of an
 * E1/T1 over fiber modem, with a Wishbone register slave.
 * Assumes line pins are asynchronous and sampled at the bit rate made
 * from the 40 MHz clock; the far-end command channel is plain pins.
 */
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module efab_top import efab_pkg::*; #(
   parameter int BER_WINDOW = BER_WINDOW_DEF,
   parameter int BLINK_CYCLES = BLINK_CYCLES_DEF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Electrical tributary
   input wire logic elec_rx_pos,
   input wire logic elec_rx_neg,
   input wire logic elec_level_low,
   output logic elec_tx_pos,
   output logic elec_tx_neg,
   // Optical link
   input wire logic opt_rx_bit,
   input wire logic opt_rx_cv,
   output logic opt_tx_bit,
   // Panel unit and far end requests
   input wire logic [3:0] attached_panel_unit_req,
   input wire logic [2:0] remote_req,
   output logic [2:0] remote_cmd,
   // Indicators and alarms
   output logic led_elec_low,
   output logic led_elec_ais,
   output logic led_opt_err,
   output logic led_opt_ais,
   output logic led_test,
   output logic led_err,
   output logic alarm_out,
   output logic irq
);

   // =====================================================================
   // State
   typedef struct packed {
      logic [PIN_W-1:0] s1;
      logic [PIN_W-1:0] s2;
      logic [NCO_W-1:0] acc;
      logic tick;
      logic dec_pol;
      logic [7:0] dec_d;
      logic [2:0] dec_vh;
      logic dec_clr;
      logic [15:0] enc_sym;
      logic enc_pol;
      logic enc_par;
      logic [9:0] run_e;
      logic [9:0] run_o;
      logic [19:0] ber_bits;
      logic [4:0] ber_errs;
      logic opt_err;
      logic ber_high;
      logic [8:0] prbs;
      logic [8:0] chk;
      logic [15:0] bert_cnt;
      logic [23:0] blink;
      logic [CTRL_W-1:0] ctrl;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      logic [IRQ_W-2:0] lvl_prev;
      logic ack;
      logic [31:0] rdata;
      logic epos;
      logic eneg;
      logic otx;
      logic [2:0] rcmd;
      logic [5:0] leds;
      logic alarm;
      logic irq;
   } efab_state_type;

   efab_state_type st_r;
   efab_state_type st_nxt;

   // Either bus, panel unit or far end may start a test
   function automatic logic req_on(input logic bus, input logic pu,
                                   input logic rem);
      return bus | pu | rem;
   endfunction

   logic [PIN_W-1:0] pins;
   assign pins = {remote_req, attached_panel_unit_req, opt_rx_cv,
                  opt_rx_bit, elec_level_low, elec_rx_neg, elec_rx_pos};

   // =====================================================================
   // Next state
   always_comb begin
      logic [NCO_W:0] sum;
      logic [3:0] pu;
      logic [2:0] rem;
      logic t1, local_loopback, dlb, bert, ledchk, test;
      logic pulse, viol, rx_e, rx_o, src, ebit, chk_err;
      logic [1:0] osym;
      logic [IRQ_W-2:0] lvl;
      logic [IRQ_W-1:0] ev, clr;
      logic wr, alarm;
      int emit;
      sum = '0;
      pu = '0;
      rem = '0;
      t1 = 1'b0;
      local_loopback = 1'b0;
      dlb = 1'b0;
      bert = 1'b0;
      ledchk = 1'b0;
      test = 1'b0;
      pulse = 1'b0;
      viol = 1'b0;
      rx_e = 1'b0;
      rx_o = 1'b0;
      src = 1'b0;
      ebit = 1'b0;
      chk_err = 1'b0;
      osym = SYM_ZERO;
      lvl = '0;
      ev = '0;
      clr = '0;
      wr = 1'b0;
      alarm = 1'b0;
      emit = 0;
      st_nxt = st_r;
      st_nxt.s1 = pins;
      st_nxt.s2 = st_r.s1;
      pu = st_r.s2[P_PU +: 4];
      rem = st_r.s2[P_REM +: 3];
      t1 = st_r.ctrl[CB_T1];
      local_loopback = req_on(st_r.ctrl[CB_LLB], pu[RQ_LLB], rem[RQ_LLB]); // see [R14]
      dlb = rem[RQ_RLB]; // see [R15]
      bert = req_on(st_r.ctrl[CB_BERT], pu[RQ_BERT], rem[RQ_BERT]);
      ledchk = st_r.ctrl[CB_LEDCHK] | pu[RQ_LEDCHK];
      test = local_loopback | dlb | bert | st_r.ctrl[CB_RLB] | pu[RQ_RLB];
      // Bit clock from a phase accumulator; no recovered clock domain
      sum = {1'b0, st_r.acc} + {1'b0, t1 ? INC_T1 : INC_E1}; // see [R07]
      st_nxt.acc = sum[NCO_W-1:0];
      st_nxt.tick = sum[NCO_W];

      if (st_r.tick) begin
         // ==================================================================
         // Electrical receive decoder, eight bits of delay
         pulse = st_r.s2[P_EPOS] ^ st_r.s2[P_ENEG];
         viol = pulse && (st_r.s2[P_EPOS] == st_r.dec_pol);
         rx_e = st_r.dec_d[7];
         st_nxt.dec_d = {st_r.dec_d[6:0], pulse & ~st_r.dec_clr};
         st_nxt.dec_clr = 1'b0;
         if (pulse) begin
            st_nxt.dec_pol = st_r.s2[P_EPOS];
         end
         if (!t1 && viol) begin
            st_nxt.dec_d[3:0] = 4'h0; // see [R08]
         end else if (t1 && viol && st_r.dec_vh[2]) begin
            st_nxt.dec_d[6:0] = 7'h00; // see [R08]
            st_nxt.dec_clr = 1'b1;
         end
         st_nxt.dec_vh = {st_r.dec_vh[1:0], viol};
         // Local loop feeds our own fiber output back into the receive path
         rx_o = local_loopback ? st_r.otx : st_r.s2[P_OBIT]; // see [R14]

         // ==================================================================
         // Toward the fiber
         src = dlb ? rx_o : (bert ? st_r.prbs[PRBS_TAP_A] : rx_e); // see [R04]
         if (st_r.s2[P_ELOW]) begin
            src = 1'b1; // see [R01]
         end
         if (st_r.ber_high) begin
            src = 1'b1; // see [R02]
         end
         st_nxt.otx = src; // see [R03]
         st_nxt.prbs = {st_r.prbs[7:0],
                        st_r.prbs[PRBS_TAP_A] ^ st_r.prbs[PRBS_TAP_B]};

         // ==================================================================
         // Toward the tributary, with zero substitution
         ebit = rx_o;
         emit = t1 ? B8ZS_EMIT : HDB3_EMIT;
         osym = st_r.enc_sym[2*emit +: 2];
         st_nxt.epos = 1'b0;
         st_nxt.eneg = 1'b0;
         if (osym == SYM_MARK) begin
            st_nxt.enc_pol = ~st_r.enc_pol;
            st_nxt.enc_par = ~st_r.enc_par;
            st_nxt.epos = ~st_r.enc_pol;
            st_nxt.eneg = st_r.enc_pol;
         end else if (osym == SYM_VIOL) begin
            st_nxt.enc_par = 1'b0;
            st_nxt.epos = st_r.enc_pol;
            st_nxt.eneg = ~st_r.enc_pol;
         end
         st_nxt.enc_sym = {st_r.enc_sym[13:0], ebit ? SYM_MARK : SYM_ZERO};
         if (t1 && st_nxt.enc_sym == 16'h0000) begin
            st_nxt.enc_sym = {SYM_ZERO, SYM_ZERO, SYM_ZERO, SYM_VIOL,
                              SYM_MARK, SYM_ZERO, SYM_VIOL, SYM_MARK}; // see [R08]
         end else if (!t1 && st_nxt.enc_sym[7:0] == 8'h00) begin
            st_nxt.enc_sym[1:0] = SYM_VIOL; // see [R08]
            if (!st_nxt.enc_par) begin
               st_nxt.enc_sym[7:6] = SYM_MARK;
            end
         end

         // ==================================================================
         // All-ones runs on both inputs
         st_nxt.run_e = !rx_e ? 10'h000 :
                        (st_r.run_e == AIS_RUN ? AIS_RUN : st_r.run_e + 10'h001);
         st_nxt.run_o = !rx_o ? 10'h000 :
                        (st_r.run_o == AIS_RUN ? AIS_RUN : st_r.run_o + 10'h001);

         // ==================================================================
         // Optical error rate over a fixed window of bits
         if (st_r.s2[P_OCV] && st_r.ber_errs != 5'h1f) begin
            st_nxt.ber_errs = st_r.ber_errs + 5'h01;
         end
         if (st_r.ber_bits == 20'(BER_WINDOW - 1)) begin
            st_nxt.ber_bits = '0;
            st_nxt.ber_errs = '0;
            st_nxt.ber_high = st_r.ber_errs > BER5_LIMIT; // see [R02]
            st_nxt.opt_err = st_r.ber_errs >= BER6_LIMIT; // see [R12]
         end else begin
            st_nxt.ber_bits = st_r.ber_bits + 20'h00001;
         end

         // ==================================================================
         // Self-synchronising checker
         if (bert) begin
            chk_err = rx_o ^ (st_r.chk[PRBS_TAP_A] ^ st_r.chk[PRBS_TAP_B]); // see [R18]
            st_nxt.chk = {st_r.chk[7:0], rx_o};
            if (chk_err && st_r.bert_cnt != 16'hffff) begin
               st_nxt.bert_cnt = st_r.bert_cnt + 16'h0001; // see [R05]
            end
         end
      end
      if (!bert) begin
         st_nxt.bert_cnt = '0;
      end
      if (chk_err) begin
         st_nxt.blink = 24'(BLINK_CYCLES);
      end else if (st_r.blink != 24'h000000) begin
         st_nxt.blink = st_r.blink - 24'h000001;
      end

      // =====================================================================
      // Indicators and interrupt
      alarm = st_r.s2[P_ELOW] | (st_r.run_e == AIS_RUN) |
              (st_r.run_o == AIS_RUN) | st_r.opt_err | st_r.ber_high;
      st_nxt.alarm = alarm; // see [R03]
      st_nxt.leds = {alarm | (st_r.blink != 24'h000000 &&
                              st_r.blink[BLINK_PHASE_BIT]), // see [R06]
                     test, // see [R13]
                     st_r.run_o == AIS_RUN, // see [R11]
                     st_r.opt_err, // see [R12]
                     st_r.run_e == AIS_RUN, // see [R10]
                     st_r.s2[P_ELOW]}; // see [R09]
      if (ledchk) begin
         st_nxt.leds = '1; // see [R17]
      end
      // Far end is asked to loop; combined mode adds the local tester
      st_nxt.rcmd = {1'b0, st_r.ctrl[CB_RLB] | pu[RQ_RLB], 1'b0}; // see [R16]
      lvl = {st_r.ber_high, st_r.opt_err, st_r.run_o == AIS_RUN,
             st_r.run_e == AIS_RUN, st_r.s2[P_ELOW]};
      st_nxt.lvl_prev = lvl;
      ev = {chk_err, lvl & ~st_r.lvl_prev};

      // =====================================================================
      // Wishbone slave, one wait state
      st_nxt.ack = wb_cyc_i & wb_stb_i & ~st_r.ack;
      wr = st_nxt.ack & wb_we_i & wb_sel_i[0];
      if (wr && wb_adr_i == ADDR_CTRL) begin
         st_nxt.ctrl = wb_dat_i[CTRL_W-1:0];
      end
      if (wr && wb_adr_i == ADDR_IRQ_MASK) begin
         st_nxt.irq_mask = wb_dat_i[IRQ_W-1:0];
      end
      if (wr && wb_adr_i == ADDR_IRQ_STAT) begin
         clr = wb_dat_i[IRQ_W-1:0];
      end
      // A new event outranks a clear in the same cycle
      st_nxt.irq_stat = (st_r.irq_stat & ~clr) | ev;
      st_nxt.irq = |(st_r.irq_stat & st_r.irq_mask);
      unique case (wb_adr_i)
         ADDR_CTRL: st_nxt.rdata = 32'(st_r.ctrl);
         ADDR_STATUS: st_nxt.rdata = 32'({bert, test, lvl});
         ADDR_IRQ_STAT: st_nxt.rdata = 32'(st_r.irq_stat);
         ADDR_IRQ_MASK: st_nxt.rdata = 32'(st_r.irq_mask);
         ADDR_BERT_CNT: st_nxt.rdata = 32'(st_r.bert_cnt);
         default: st_nxt.rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_r <= '0;
         st_r.prbs <= PRBS_SEED;
      end else begin
         st_r <= st_nxt;
      end
   end

   // =====================================================================
   // Outputs
   assign wb_dat_o = st_r.rdata;
   assign wb_ack_o = st_r.ack;
   assign elec_tx_pos = st_r.epos;
   assign elec_tx_neg = st_r.eneg;
   assign opt_tx_bit = st_r.otx;
   assign remote_cmd = st_r.rcmd;
   assign {led_err, led_test, led_opt_ais, led_opt_err, led_elec_ais,
           led_elec_low} = st_r.leds;
   assign alarm_out = st_r.alarm;
   assign irq = st_r.irq;

   // =====================================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_low_forces_ais: assert property (st_r.tick && st_r.s2[P_ELOW]
      |=> st_r.otx) else $error("low input did not force all-ones"); // see [R01]
   a_ber_forces_ais: assert property (st_r.tick && st_r.ber_high
      |=> st_r.otx) else $error("error rate did not force all-ones"); // see [R02]
   a_prbs_step: assert property (st_r.tick |=> st_r.prbs ==
      {$past(st_r.prbs[7:0]), $past(st_r.prbs[8] ^ st_r.prbs[4])})
      else $error("pattern register stepped wrongly"); // see [R04]
   a_bert_count: assert property (st_r.tick && st_r.ctrl[CB_BERT] &&
      st_r.s2[P_REM+RQ_LLB] == 1'b0 && !st_r.ctrl[CB_LLB] &&
      !st_r.s2[P_PU+RQ_LLB] &&
      (st_r.s2[P_OBIT] != (st_r.chk[8] ^ st_r.chk[4])) &&
      st_r.bert_cnt < 16'h00ff |=> st_r.bert_cnt == $past(st_r.bert_cnt) + 16'h0001)
      else $error("mismatch not counted"); // see [R05]
   a_err_led_alarm: assert property (st_r.alarm |-> st_r.leds[5])
      else $error("error LED dark during alarm"); // see [R06]
   a_elec_low_led: assert property (st_r.s2[P_ELOW] |=> led_elec_low)
      else $error("electrical-low LED dark"); // see [R09]
   a_opt_ais_led: assert property (st_r.run_o == AIS_RUN ##1 1'b1
      |-> led_opt_ais) else $error("optical AIS LED dark"); // see [R11]
   a_elec_ais_led: assert property (st_r.run_e == AIS_RUN |=> led_elec_ais)
      else $error("electrical AIS LED dark"); // see [R10]
   a_opt_err_led: assert property (st_r.opt_err |=> led_opt_err)
      else $error("optical error LED dark"); // see [R12]
   a_test_led: assert property (st_r.ctrl[CB_BERT] |=> led_test)
      else $error("test LED dark during test"); // see [R13]
   a_led_check: assert property (st_r.ctrl[CB_LEDCHK] |=> &st_r.leds)
      else $error("LED check left an LED dark"); // see [R17]

endmodule
`default_nettype wire

// File: hw/efab_pkg.sv
/*
 * Constants, register map and state encodings of the E1/T1 fiber modem
 * alarm, AIS, loopback and bit error tester block.
 * Assumes a single 40 MHz system clock and a classic Wishbone register bus.
 */
// Functional notes
// [R01] Electrical input below line level forces all-ones toward the fiber.
// [R02] Optical error rate above 1e-5 forces all-ones toward the fiber.
// [R03] Incoming all-ones on either side passes through and raises alarms.
// [R04] Active test sends a repeating 511-bit pseudo-random pattern to the far end.
// [R05] Checker compares each received bit with the pattern and counts mismatches.
// [R06] Error LED steady on alarm, blinking when checked data shows errors.
// [R07] Bit rate 2.048 Mbps in E1 mode and 1.544 Mbps in T1 mode.
// [R08] Line code uses HDB3 substitution in E1 and B8ZS in T1.
// [R09] Electrical-low LED on while the input level stays below line level.
// [R10] Electrical AIS LED on while all-ones arrive on the electrical input.
// [R11] Optical AIS LED on while all-ones arrive from the fiber.
// [R12] Optical error LED on at an error rate of 1e-6 or worse.
// [R13] Test LED on while any test runs, local or remote started.
// [R14] Local loopback, startable from panel, panel unit or far end.
// [R15] Remote digital loopback at the far modem, startable from any source.
// [R16] Combined mode: far end loops while the local tester runs over it.
// [R17] Indicator check drives every LED on, from panel or panel unit.
// [R18] Pattern from x^9+x^5+1 register; checker self-synchronises.
package efab_pkg;

   // =====================================================================
   // Timing
   localparam longint CLK_HZ = 40_000_000;
   localparam longint E1_BPS = 2_048_000;
   localparam longint T1_BPS = 1_544_000;
   localparam int NCO_W = 16;
   localparam logic [NCO_W-1:0] INC_E1 = NCO_W'((E1_BPS << NCO_W) / CLK_HZ);
   localparam logic [NCO_W-1:0] INC_T1 = NCO_W'((T1_BPS << NCO_W) / CLK_HZ);
   localparam int BLINK_MS = 250;
   localparam int BLINK_CYCLES_DEF = int'(CLK_HZ / 1000) * BLINK_MS;
   localparam int BLINK_PHASE_BIT = 21;
   localparam int BER_WINDOW_DEF = 1_000_000;
   localparam logic [4:0] BER5_LIMIT = 5'h0a;
   localparam logic [4:0] BER6_LIMIT = 5'h01;
   localparam logic [9:0] AIS_RUN = 10'h200;

   // =====================================================================
   // Registers
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
   localparam logic [7:0] ADDR_BERT_CNT = 8'h10;
   localparam int CB_T1 = 0;
   localparam int CB_LLB = 1;
   localparam int CB_RLB = 2;
   localparam int CB_BERT = 3;
   localparam int CB_LEDCHK = 4;
   localparam int CTRL_W = 5;
   localparam int IRQ_W = 6;
   localparam int IB_BERT_ERR = 5;

   // =====================================================================
   // Pins, requests, line symbols, pattern
   localparam int PIN_W = 12;
   localparam int P_EPOS = 0;
   localparam int P_ENEG = 1;
   localparam int P_ELOW = 2;
   localparam int P_OBIT = 3;
   localparam int P_OCV = 4;
   localparam int P_PU = 5;
   localparam int P_REM = 9;
   localparam int RQ_LLB = 0;
   localparam int RQ_RLB = 1;
   localparam int RQ_BERT = 2;
   localparam int RQ_LEDCHK = 3;
   localparam logic [1:0] SYM_ZERO = 2'h0;
   localparam logic [1:0] SYM_MARK = 2'h1;
   localparam logic [1:0] SYM_VIOL = 2'h2;
   localparam int HDB3_EMIT = 3;
   localparam int B8ZS_EMIT = 7;
   localparam int PRBS_TAP_A = 8;
   localparam int PRBS_TAP_B = 4;
   localparam logic [8:0] PRBS_SEED = 9'h1ff;

endpackage

// File: testbench/efab_peer_model.sv
/*
 * Far-end peer modem on the fiber: idle traffic, digital loopback on
 * request, and commanded faults (all-ones, code violations, bit flips).
 * Assumes the bench changes its control inputs just after clk edges.
 */
`timescale 1ns/1ps
`default_nettype none
module efab_peer_model (
   // Clock
   input wire logic clk,
   // Fiber toward and from the block
   input wire logic tx_bit,
   output logic rx_bit,
   output logic rx_cv,
   // Loop request and commanded faults
   input wire logic cmd_loop,
   input wire logic ais_en,
   input wire logic cv_en,
   input wire logic flip_en
);
   logic [4:0] idle_r = 5'h00;

   // =====================================================================
   // Idle traffic
   // Slow square wave, never long enough to look like all-ones
   always_ff @(posedge clk) begin
      idle_r <= idle_r + 5'h01;
   end

   // =====================================================================
   // Far-end loop and faults
   // Loop is wire-level, so it adds no bit delay; flips only on command
   assign rx_bit = ais_en ? 1'b1 :
                   cmd_loop ? (tx_bit ^ flip_en) : idle_r[4];
   assign rx_cv = cv_en;
endmodule
`default_nettype wire

// File: testbench/e1t1_fiber_alarm_bert_tb.sv
/*
 * Self-checking bench of the E1/T1 fiber alarm, AIS and tester block.
 * Assumes the peer model on the fiber; the bench loops the electrical
 * transmit rails back into the receiver while eloop is set.
 */
`timescale 1ns/1ps
`default_nettype none
module e1t1_fiber_alarm_bert_tb import efab_pkg::*;;
   logic clk, resetn, wb_cyc, wb_stb, wb_we, wb_ack;
   logic [7:0] wb_adr;
   logic [31:0] wb_wdat, wb_rdat, rd, c0;
   logic elec_low, etx_pos, etx_neg, eloop;
   logic opt_rx, opt_cv, opt_tx, alarm_out, irq, ais_en, cv_en, flip_en;
   logic [3:0] apu_req;
   logic [2:0] remote_req, remote_cmd;
   logic [5:0] leds;
   int n_mismatch = 0;
   int num_checks = 0;
   int g;

   efab_top #(.BER_WINDOW(100), .BLINK_CYCLES(64)) uut (
      .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
      .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .elec_rx_pos(eloop & etx_pos), .elec_rx_neg(eloop & etx_neg),
      .elec_level_low(elec_low), .elec_tx_pos(etx_pos),
      .elec_tx_neg(etx_neg), .opt_rx_bit(opt_rx), .opt_rx_cv(opt_cv),
      .opt_tx_bit(opt_tx), .attached_panel_unit_req(apu_req),
      .remote_req(remote_req), .remote_cmd(remote_cmd),
      .led_elec_low(leds[0]), .led_elec_ais(leds[1]), .led_opt_err(leds[2]),
      .led_opt_ais(leds[3]), .led_test(leds[4]), .led_err(leds[5]),
      .alarm_out(alarm_out), .irq(irq));

   efab_peer_model peer (.clk(clk), .tx_bit(opt_tx), .rx_bit(opt_rx),
      .rx_cv(opt_cv), .cmd_loop(remote_cmd[1]), .ais_en(ais_en),
      .cv_en(cv_en), .flip_en(flip_en));

   // =====================================================================
   // Common tasks
   task automatic end_of_test;
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Called just after a rising edge; request held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      rd = wb_rdat;
      if (n >= 50) n_mismatch++;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wait_led(input int idx, input logic v, input int lim);
      for (int i = 0; i < lim; i++) begin
         @(posedge clk);
         if (leds[idx] === v) break;
      end
   endtask

   task automatic count_zeros(input int n, output int bad);
      bad = 0;
      repeat (n) begin
         @(posedge clk);
         if (opt_tx !== 1'b1) bad++;
      end
   endtask

   // Shortest run between fiber transitions is one bit period
   task automatic gap_min(output int gm);
      int c;
      logic p;
      c = -100000;
      gm = 1000;
      p = opt_tx;
      repeat (3000) begin
         @(posedge clk);
         c++;
         if (opt_tx !== p) begin
            if (c > 0 && c < gm) gm = c;
            c = 0;
            p = opt_tx;
         end
      end
   endtask

   // =====================================================================
   // Scenarios
   task automatic t_regs;
      logic [7:0] adrs [6] = '{ADDR_CTRL, ADDR_STATUS, ADDR_IRQ_STAT,
                               ADDR_IRQ_MASK, ADDR_BERT_CNT, 8'h20};
      foreach (adrs[i]) begin
         wb(1'b0, adrs[i], 32'h0);
         chk(rd, 32'h0);
      end
      chk(32'(leds), 32'h0);
      wb(1'b1, ADDR_CTRL, 32'h1);
      wb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, 32'h1);
      wb(1'b1, ADDR_CTRL, 32'h0);
      wb(1'b1, ADDR_STATUS, 32'hff);
      wb(1'b1, 8'h20, 32'hff);
      wb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, 32'h0);
   endtask

   task automatic t_elec_low;
      int bad;
      wb(1'b1, ADDR_IRQ_MASK, 32'h01);
      elec_low <= 1'b1;
      wait_led(0, 1'b1, 20);
      chk(leds[0], 1'b1);
      repeat (60) @(posedge clk);
      count_zeros(400, bad);
      chk(32'(bad), 32'h0);
      chk(irq, 1'b1);
      wb(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk(rd, 32'h1);
      wb(1'b1, ADDR_IRQ_MASK, 32'h0);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      elec_low <= 1'b0;
      wait_led(0, 1'b0, 20);
      chk(leds[0], 1'b0);
      wb(1'b1, ADDR_IRQ_STAT, 32'h3f);
      wb(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk(rd, 32'h0);
   endtask

   task automatic t_ais;
      int bad;
      ais_en <= 1'b1;
      wait_led(3, 1'b1, 12000);
      chk(leds[3], 1'b1);
      chk(alarm_out, 1'b1);
      chk(leds[5], 1'b1);
      eloop <= 1'b1;
      wait_led(1, 1'b1, 12000);
      chk(leds[1], 1'b1);
      count_zeros(200, bad);
      chk(32'(bad), 32'h0);
      wb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[2:0], 3'h6);
      ais_en <= 1'b0;
      eloop <= 1'b0;
      wait_led(3, 1'b0, 600);
      chk(leds[3], 1'b0);
      wait_led(1, 1'b0, 600);
      chk(leds[1], 1'b0);
      wb(1'b1, ADDR_IRQ_STAT, 32'h3f);
   endtask

   task automatic t_ber;
      int bad;
      // Two or so flagged bits: above one per million, below 1e-5
      cv_en <= 1'b1;
      repeat (40) @(posedge clk);
      cv_en <= 1'b0;
      wait_led(2, 1'b1, 4500);
      chk(leds[2], 1'b1);
      wb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[4], 1'b0);
      cv_en <= 1'b1;
      repeat (4500) @(posedge clk);
      wb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[4:3], 2'h3);
      count_zeros(500, bad);
      chk(32'(bad), 32'h0);
      cv_en <= 1'b0;
      repeat (4500) @(posedge clk);
      wb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd[4:3], 2'h0);
      wb(1'b1, ADDR_IRQ_STAT, 32'h3f);
   endtask

   task automatic t_bert;
      wb(1'b1, ADDR_CTRL, 32'((1 << CB_RLB) | (1 << CB_BERT)));
      repeat (4) @(posedge clk);
      chk(remote_cmd, 3'h2);
      chk(leds[4], 1'b1);
      gap_min(g);
      chk(32'(g), 32'(40000000 / 2048000));
      repeat (1000) @(posedge clk);
      wb(1'b1, ADDR_IRQ_STAT, 32'h3f);
      wb(1'b0, ADDR_BERT_CNT, 32'h0);
      c0 = rd;
      repeat (2000) @(posedge clk);
      wb(1'b0, ADDR_BERT_CNT, 32'h0);
      chk(rd, c0);
      wb(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk(rd[5], 1'b0);
      flip_en <= 1'b1;
      repeat (60) @(posedge clk);
      flip_en <= 1'b0;
      repeat (600) @(posedge clk);
      wb(1'b0, ADDR_BERT_CNT, 32'h0);
      chk(rd > c0, 1'b1);
      wb(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk(rd[5], 1'b1);
      wb(1'b1, ADDR_CTRL, 32'h0d);
      repeat (100) @(posedge clk);
      gap_min(g);
      chk(32'(g), 32'(40000000 / 1544000));
      wb(1'b1, ADDR_CTRL, 32'h0);
      repeat (4) @(posedge clk);
      chk(remote_cmd, 3'h0);
      wb(1'b0, ADDR_BERT_CNT, 32'h0);
      chk(rd, 32'h0);
      wb(1'b1, ADDR_IRQ_STAT, 32'h3f);
   endtask

   task automatic t_tests;
      for (int i = 0; i < 3; i++) begin
         remote_req <= 3'(1 << i);
         repeat (8) @(posedge clk);
         chk(leds[4], 1'b1);
         remote_req <= 3'h0;
         apu_req <= 4'(1 << i);
         repeat (8) @(posedge clk);
         chk(leds[4], 1'b1);
         chk(remote_cmd[1], i == 1);
         apu_req <= 4'h0;
         repeat (8) @(posedge clk);
         chk(leds[4], 1'b0);
      end
      apu_req <= 4'h8;
      repeat (8) @(posedge clk);
      chk(32'(leds), 32'h3f);
      apu_req <= 4'h0;
      wb(1'b1, ADDR_CTRL, 32'(1 << CB_LEDCHK));
      repeat (4) @(posedge clk);
      chk(32'(leds), 32'h3f);
      wb(1'b1, ADDR_CTRL, 32'h0);
      repeat (4) @(posedge clk);
      chk(32'(leds), 32'h0);
   endtask

   // =====================================================================
   // Clock, reset, sequence and watchdog
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      resetn = 1'b0;
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} = '0;
      {elec_low, eloop, ais_en, cv_en, flip_en} = '0;
      apu_req = 4'h0;
      remote_req = 3'h0;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      t_regs;
      t_elec_low;
      t_ais;
      t_ber;
      t_bert;
      t_tests;
      end_of_test;
   end

   // Tests take about 42k cycles; alarm windows may run late
   initial begin
      repeat (90000) @(posedge clk);
      n_mismatch++;
      end_of_test;
   end
endmodule
`default_nettype wire
